// ---- hdl/wdog_pkg.sv ----
// Package for the watchdog reset supervisor: register map, field layout, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package wdog_pkg;
    localparam logic [11:0] ctrl_addr        = 12'h000;
    localparam logic [11:0] count_addr       = 12'h004;
    localparam logic [11:0] status_addr      = 12'h008;
    localparam int          div_sel_bit      = 0;
    localparam int          ovf_flag_bit     = 1;
    localparam int          sw_flag_bit      = 2;
    localparam int          short_flag_bit   = 3;
    localparam int          long_flag_bit    = 4;
    localparam logic [15:0] ctrl_rst_ext     = 16'h001c;
    localparam logic [15:0] ctrl_rst_sw      = 16'h0004;
    localparam logic [15:0] ctrl_rst_wdog    = 16'h0006;
    localparam logic [15:0] ctrl_wr_mask     = 16'hff01;
    localparam logic [15:0] ctrl_end_init_instruction_clr   = 16'hffe1;
    localparam logic [6:0]  div_slow_last    = 7'h7f;
    localparam logic [6:0]  div_fast_last    = 7'h01;
    localparam logic [15:0] count_last       = 16'hffff;
    localparam logic [3:0]  reset_hold_cyc   = 4'h8;

    typedef enum logic [1:0] {
        rst_ext,
        rst_sw,
        rst_wdog
    } rst_cause_e;

    typedef struct packed {
        logic service;
        logic service_bad;
        logic disable_req;
        logic end_init;
        logic soft_reset;
    } cpu_req_s;

    typedef struct packed {
        logic busy;
        logic ready_ignored;
        logic ready_seen;
    } bus_cycle_s;
endpackage

// ---- hdl/wdog_prescaler.sv ----
// Prescaler giving a one-cycle count enable at fCPU/2 or fCPU/128.
// Assumes pclk is the CPU clock.
`timescale 1ns/1ns
module wdog_prescaler
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic clear,
    input  wire logic slow_sel,
    // Tick
    output logic      tick
);
    import wdog_pkg::*;

    logic [6:0] div_q;
    logic [6:0] last;

    assign last = slow_sel ? div_slow_last : div_fast_last;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 7'h00;
            tick  <= 1'b0;
        end
        else if (clear)
        begin
            div_q <= 7'h00;
            tick  <= 1'b0;
        end
        else
        begin
            tick <= (div_q >= last);
            if (div_q >= last)
                div_q <= 7'h00;
            else
                div_q <= div_q + 7'h01;
        end
    end
endmodule

// ---- hdl/wdog_supervisor.sv ----
// Watchdog timer and reset supervisor with an APB register port.
// Assumes CPU requests are one-cycle pulses synchronous to pclk and that the
// system reset controller acts on the internal reset request it drives.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns

// Summary of operation
// - The timer is a 16-bit up counter of a low byte feeding a high byte, stepped by a prescaler.
// - The divider select bit chooses fCPU/2 when zero and fCPU/128 when one.
// - The count register is read-only and always shows the live count.
// - Reaching FFFF unserviced overflows and starts an internal reset that drives the output low.
// - Overflow sets the overflow flag; a hardware reset or a service clears it.
// - After any reset except a hardware reset into bootstrap mode, the timer is enabled and counts from zero at fCPU/2.
// - Disable works only until the first end-of-init or service, and is ignored after.
// - The timer keeps counting in idle mode unless disabled.
// - Service clears the low byte and loads the high byte from the reload field.
// - A malformed service does not service and raises the protection fault trap.
// - Reset sources load the control register with 001C, 0004 or 0006.
// - End-of-init clears control bits 4 down to 1.
// - A watchdog reset request rises two cycles after the overflow flag sets and aborts a running bus cycle unless it ignores or saw ready.
// - A hardware reset into bootstrap mode leaves the timer disabled.
module wdog_supervisor
(
    // APB clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // CPU core requests
    input  wdog_pkg::cpu_req_s         cpu_req,
    input  wire logic                  idle_mode,
    input  wire logic                  bootstrap_strap,
    // External bus cycle state
    input  wdog_pkg::bus_cycle_s       bus_cycle,
    // Reset and trap outputs
    output logic                       reset_indication_output_n,
    output logic                       bus_abort,
    output logic                       protection_fault_trap,
    output logic                       internal_reset_req
);
    import wdog_pkg::*;

    typedef enum logic [1:0] {
        st_run,
        st_bus_wait,
        st_reset
    } sup_state_e;

    sup_state_e  state_q;
    logic [15:0] watchdog_control_q;
    logic [15:0] watchdog_count_q;
    logic        enabled_q;
    logic        dis_open_q;
    logic        strap_done_q;
    logic [3:0]  hold_q;
    rst_cause_e  cause_q;
    logic        tick;
    logic        service_ok;
    logic        overflow;
    logic        restart;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    assign service_ok = cpu_req.service && !cpu_req.service_bad;
    assign overflow   = enabled_q && tick && (watchdog_count_q == count_last)
                        && (state_q == st_run);
    assign restart    = (state_q == st_reset) && (hold_q == 4'h0);
    assign addr_ok    = (paddr == ctrl_addr) || (paddr == count_addr)
                        || (paddr == status_addr);
    assign wr_en      = psel && penable && pwrite && addr_ok;
    assign rd_en      = psel && !penable && !pwrite;

    wdog_prescaler u_prescaler
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (service_ok || restart || cpu_req.soft_reset),
        .slow_sel (watchdog_control_q[div_sel_bit]),
        .tick     (tick)
    );

    // Counter runs regardless of idle mode; idle is deliberately not a term here.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            watchdog_count_q <= 16'h0000;
        else if (restart || cpu_req.soft_reset)
            watchdog_count_q <= 16'h0000;
        else if (service_ok)
            watchdog_count_q <= {watchdog_control_q[15:8], 8'h00};
        else if (enabled_q && tick && state_q == st_run)
            watchdog_count_q <= watchdog_count_q + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            watchdog_control_q <= ctrl_rst_ext;
        else if (restart)
            watchdog_control_q <= (cause_q == rst_wdog) ? ctrl_rst_wdog : ctrl_rst_sw;
        else if (cpu_req.soft_reset)
            watchdog_control_q <= ctrl_rst_sw;
        else
        begin
            if (wr_en && paddr == ctrl_addr)
                watchdog_control_q <= (watchdog_control_q & ~ctrl_wr_mask)
                                      | (pwdata[15:0] & ctrl_wr_mask);
            if (cpu_req.end_init)
                watchdog_control_q[4:1] <= 4'h0;
            if (service_ok)
                watchdog_control_q[ovf_flag_bit] <= 1'b0;
            if (overflow)
                watchdog_control_q[ovf_flag_bit] <= 1'b1;
        end
    end

    // Bootstrap strap is caught on the first clocked edge after release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enabled_q    <= 1'b1;
            strap_done_q <= 1'b0;
            dis_open_q   <= 1'b1;
        end
        else
        begin
            strap_done_q <= 1'b1;
            if (!strap_done_q && bootstrap_strap)
                enabled_q <= 1'b0;
            else if (restart || cpu_req.soft_reset)
                enabled_q <= 1'b1;
            else if (cpu_req.disable_req && dis_open_q)
                enabled_q <= 1'b0;
            if (restart || cpu_req.soft_reset)
                dis_open_q <= 1'b1;
            else if (service_ok || cpu_req.end_init)
                dis_open_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q   <= st_run;
            hold_q    <= 4'h0;
            cause_q   <= rst_ext;
            bus_abort <= 1'b0;
        end
        else
        begin
            bus_abort <= 1'b0;
            case (state_q)
                st_run:
                begin
                    if (overflow)
                    begin
                        cause_q <= rst_wdog;
                        state_q <= st_bus_wait;
                    end
                    else if (cpu_req.soft_reset)
                        cause_q <= rst_sw;
                end
                st_bus_wait:
                begin
                    hold_q  <= reset_hold_cyc;
                    if (!bus_cycle.busy || bus_cycle.ready_ignored || bus_cycle.ready_seen)
                        state_q <= st_reset;
                    else
                    begin
                        bus_abort <= 1'b1;
                        state_q   <= st_reset;
                    end
                end
                st_reset:
                begin
                    if (hold_q == 4'h0)
                        state_q <= st_run;
                    else
                        hold_q <= hold_q - 4'h1;
                end
                default:
                    state_q <= st_run;
            endcase
        end
    end

    // Reset output is held low for the whole internal reset sequence.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_indication_output_n <= 1'b0;
            internal_reset_req        <= 1'b0;
            protection_fault_trap     <= 1'b0;
        end
        else
        begin
            reset_indication_output_n <= !(state_q == st_reset && !restart);
            internal_reset_req        <= (state_q == st_reset) && !restart;
            protection_fault_trap     <= cpu_req.service && cpu_req.service_bad;
        end
    end

    // Single-cycle access phase; reads are prepared during setup.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en)
            begin
                case (paddr)
                    ctrl_addr:   prdata <= {16'h0000, watchdog_control_q};
                    count_addr:  prdata <= {16'h0000, watchdog_count_q};
                    status_addr: prdata <= {29'h00000000, dis_open_q, enabled_q,
                                            state_q != st_run};
                    default:     prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ---- verification/cpu_core_model.sv ----
// Model of the CPU core issuing the protected watchdog instructions.
// Assumes callers enter its task just after a rising edge of pclk.
`timescale 1ns/1ns
module cpu_core_model
(
    // Clock
    input  wire logic         pclk,
    // Requests
    output wdog_pkg::cpu_req_s cpu_req
);
    import wdog_pkg::*;
    initial cpu_req = '0;
    // One pulse per instruction; a bad encoding also sets service_bad.
    task automatic issue(input logic [4:0] c);
        cpu_req <= cpu_req_s'(c);
        @(posedge pclk);
        cpu_req <= '0;
        @(posedge pclk);
    endtask
endmodule

// ---- verification/wdog_props.sv ----
// Port checker for the watchdog supervisor.
// Assumes it is bound to the supervisor, whose ports share these names.
`timescale 1ns/1ns
module wdog_props
(
    // Clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // Bus
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic            pready,
    input wire logic [31:0]     prdata,
    // Core side
    input wdog_pkg::cpu_req_s   cpu_req,
    input wdog_pkg::bus_cycle_s bus_cycle,
    input wire logic            reset_indication_output_n,
    input wire logic            bus_abort,
    input wire logic            protection_fault_trap,
    input wire logic            internal_reset_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_trap; cpu_req.service && cpu_req.service_bad |=> protection_fault_trap; endproperty
    a_trap: assert property (p_trap) else $error("no trap");
    property p_cause; protection_fault_trap |-> $past(cpu_req.service_bad); endproperty
    a_cause: assert property (p_cause) else $error("stray trap");
    property p_low; internal_reset_req |-> !reset_indication_output_n; endproperty
    a_low: assert property (p_low) else $error("output high");
    property p_len; $rose(internal_reset_req) |-> internal_reset_req [*8]; endproperty
    a_len: assert property (p_len) else $error("reset short");
    property p_ab; bus_abort |-> $past(bus_cycle) == 3'b100; endproperty
    a_ab: assert property (p_ab) else $error("bad abort");
    property p_abr; bus_abort |-> ##[0:2] internal_reset_req; endproperty
    a_abr: assert property (p_abr) else $error("abort alone");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_hi; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper set");
    c_trap: cover property (protection_fault_trap);
    c_rst: cover property ($rose(internal_reset_req));
    c_ab: cover property (bus_abort);
endmodule
bind wdog_supervisor wdog_props props_i (.*);

// ---- verification/wdog_supervisor_tb.sv ----
// Self-checking bench for the watchdog supervisor.
// Assumes the package, design, core model and checker are compiled first.
`timescale 1ns/1ns
module wdog_supervisor_tb;
    import wdog_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] r;
    logic [31:0] c;
    logic        err;
    logic        idle;
    logic        strap;
    bus_cycle_s  bus;
    cpu_req_s    req;
    logic        out_n;
    logic        irr;
    logic        abort;
    logic        trap;
    int          traps = 0;
    int          aborts = 0;
    int          failures = 0;
    int          comparisons = 0;
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;
    // Pulse outputs stand for one cycle only, so they are counted as they pass.
    always @(posedge pclk)
    begin
        if (trap === 1'b1)
            traps++;
        if (abort === 1'b1)
            aborts++;
    end
    cpu_core_model cpu (.pclk(pclk), .cpu_req(req));
    wdog_supervisor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_req(req), .idle_mode(idle), .bootstrap_strap(strap),
        .bus_cycle(bus), .reset_indication_output_n(out_n), .bus_abort(abort),
        .protection_fault_trap(trap), .internal_reset_req(irr));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until pready is sampled, then released at once and followed by one idle cycle.
    task automatic wr(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic span;
        wr(1'b0, count_addr, 32'h0);
        c = r;
        repeat (20) @(posedge pclk);
        wr(1'b0, count_addr, 32'h0);
    endtask
    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (irr !== v && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("reset req", v, irr);
    endtask
    task automatic t_reset;
        wr(1'b0, ctrl_addr, 32'h0);
        chk("ctrl", 32'h001c, r);
        span;
        chk("step", 1, r - c inside {[10:13]});
        wr(1'b1, count_addr, 32'hff00);
        wr(1'b0, count_addr, 32'h0);
        chk("count wr", 1, r < 32'h100);
        wr(1'b0, 12'h00c, 32'h0);
        chk("unmapped", 1, err);
    endtask
    task automatic t_service;
        wr(1'b1, ctrl_addr, 32'hff00);
        cpu.issue(5'h10);
        wr(1'b0, count_addr, 32'h0);
        chk("reload", 32'hff00, r & 32'hff00);
        cpu.issue(5'h02);
        wr(1'b0, ctrl_addr, 32'h0);
        chk("end init", 32'hff00, r);
        c = r;
        wr(1'b0, count_addr, 32'h0);
        c = r;
        chk("no trap", 0, traps);
        cpu.issue(5'h18);
        wr(1'b0, count_addr, 32'h0);
        chk("bad svc", 1, r > c);
        chk("trap", 1, traps);
    endtask
    task automatic t_slow;
        wr(1'b1, ctrl_addr, 32'h1);
        cpu.issue(5'h10);
        repeat (256) @(posedge pclk);
        wr(1'b0, count_addr, 32'h0);
        chk("slow", 1, r inside {[1:3]});
    endtask
    task automatic t_overflow;
        wr(1'b1, ctrl_addr, 32'hff00);
        cpu.issue(5'h10);
        idle <= 1'b1;
        bus <= 3'b100;
        wait_rst(1'b1);
        chk("out low", 0, out_n);
        wait_rst(1'b0);
        chk("out high", 1, out_n);
        chk("abort", 1, aborts);
        idle <= 1'b0;
        bus <= 3'b000;
        wr(1'b0, ctrl_addr, 32'h0);
        chk("wdog ctrl", 32'h0006, r);
        wr(1'b0, count_addr, 32'h0);
        chk("restart", 1, r < 32'h10);
    endtask
    task automatic t_disable;
        cpu.issue(5'h10);
        wr(1'b0, ctrl_addr, 32'h0);
        chk("flag clr", 32'h0004, r);
        cpu.issue(5'h04);
        span;
        chk("moves", 1, r > c);
        cpu.issue(5'h01);
        wr(1'b0, ctrl_addr, 32'h0);
        chk("soft ctrl", 32'h0004, r);
        cpu.issue(5'h04);
        span;
        chk("stuck", c, r);
    endtask
    // Hardware reset in mid-run with the boot strap set: the timer must stay disabled.
    task automatic t_strap;
        strap <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        strap <= 1'b0;
        span;
        chk("boot stuck", c, r);
        wr(1'b0, status_addr, 32'h0);
        chk("boot status", 32'h4, r);
        wr(1'b0, ctrl_addr, 32'h0);
        chk("hw ctrl", 32'h001c, r);
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h00000000;
        idle <= 1'b0;
        strap <= 1'b0;
        bus <= '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_service;
        t_slow;
        t_overflow;
        t_disable;
        t_strap;
        final_report;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        final_report;
    end
endmodule
